// ==== logic/status_led_fault_output.v ====
// Purpose: Network, unit, link and front status LEDs plus the fault/general output
// Assumes: One 125 MHz clock; fault sense pins are asynchronous, state inputs are synchronous
// Notes:   Notes on behaviour
// Notes on behaviour
// - Implicit-protocol mode: flash green with IP address but no valid configuration.
// - Implicit-protocol mode: steady green when connected and configured.
// - Implicit-protocol mode: steady red on IP conflict, flash red on lost connection.
// - Modbus/TCP mode: alternate red and green during power-up initialisation.
// - Modbus/TCP mode: one green flash per connection, then two-second dark pause.
// - At most three TCP connections; LED count never above three.
// - Modbus/TCP mode: flash red when an established connection is lost.
// - Unit LED flashes red during init, steady green when boards communicate.
// - Link LED lit while link exists, flashes while data is transmitted.
// - Discrete output selectable as general purpose or fault output.
// - Fault output on in normal operation, off whenever a fault is present.
// - Faults: init incomplete, motor short, heat sink over 90 C, interlock open.
// - Faults reported to host input data; host clears via output data.
// - Front LED steady green when healthy, steady red on short, heat, interlock.
// - Motor wiring faults detected only while motor current is enabled.
`timescale 1ns/1ps
`include "led_fault_regs.vh"
module status_led_fault_output (
  // Clock and reset
  input  wire       i_clock,
  input  wire       i_resetn,
  // Driver state (synchronous)
  input  wire       i_init_done,
  input  wire       i_motor_current_en,
  input  wire       i_modbus_mode,
  input  wire       i_ip_held,
  input  wire       i_ip_conflict,
  input  wire       i_config_valid,
  input  wire       i_conn_open,
  input  wire       i_conn_lost,
  input  wire [1:0] i_tcp_conn_count,
  input  wire       i_board_comm_ok,
  // Protection and link pins (asynchronous)
  input  wire       i_short_pin,
  input  wire       i_overtemp_pin,
  input  wire       i_interlock_open_pin,
  input  wire       i_link_up_pin,
  input  wire       i_link_activity,
  // Discrete output configuration
  input  wire       i_out_is_fault,
  input  wire       i_gp_out_value,
  // Host network data
  input  wire       i_host_fault_clear,
  output reg  [3:0] o_fault_report,
  // Indicators and output line
  output reg        o_net_led_green,
  output reg        o_net_led_red,
  output reg        o_unit_led_green,
  output reg        o_unit_led_red,
  output reg        o_link_led,
  output reg        o_front_led_green,
  output reg        o_front_led_red,
  output reg        o_discrete_out
);
  localparam ST_FLASH = 2'd0;
  localparam ST_PAUSE = 2'd1;
  localparam [31:0] HALF_CYC  = `FLASH_HALF_CYC;
  localparam [31:0] PAUSE_CYC = `PAUSE_CYC;
  localparam [31:0] INIT_CYC  = `INIT_FLASH_CYC;

  wire [4:0] pins;
  reg  [31:0] tick_cnt;
  reg         blink;
  reg         blink_edge;
  reg  [31:0] init_cnt;
  reg         init_window;
  reg  [1:0]  tcp_state;
  reg  [31:0] pause_cnt;
  reg  [2:0]  flash_left;
  reg  [1:0]  lost_flag;
  reg  [`FLT_W-1:0] fault_latch;
  reg  [`FLT_W-1:0] next_fault;
  reg  [1:0]  next_net;
  reg  [1:0]  next_front;
  wire [`FLT_W-1:0] fault_now;
  wire [1:0] conn_cap;

  pin_sync #(.W(5)) u_sync (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_pin    ({i_link_activity, i_link_up_pin, i_interlock_open_pin, i_overtemp_pin, i_short_pin}),
    .o_level  (pins)
  );

  // Cap on connections shown; further ones are refused upstream
  function [1:0] cap_conn;
    input [1:0] n;
    begin
      cap_conn = (n > `MAX_CONN) ? `MAX_CONN : n;
    end
  endfunction

  assign conn_cap = cap_conn(i_tcp_conn_count);

  // Wiring faults only count while current flows; heat is always watched
  // Interlock counts as motor wiring, so it is masked the same way as a short
  assign fault_now[`FLT_INIT]    = ~i_init_done;
  assign fault_now[`FLT_SHORT]   = pins[0] & i_motor_current_en;
  assign fault_now[`FLT_TEMP]    = pins[1];
  assign fault_now[`FLT_NOMOTOR] = pins[2] & i_motor_current_en;

  // Free-running blink base
  always @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      tick_cnt   <= 32'h0000_0000;
      blink      <= 1'b0;
      blink_edge <= 1'b0;
    end
    else
    begin
      blink_edge <= 1'b0;
      if (tick_cnt >= HALF_CYC - 32'h1)
      begin
        tick_cnt   <= 32'h0000_0000;
        blink      <= ~blink;
        blink_edge <= blink;
      end
      else
        tick_cnt <= tick_cnt + 32'h1;
    end
  end

  // Power-up flash window, also held while init is incomplete
  always @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      init_cnt    <= 32'h0000_0000;
      init_window <= 1'b1;
    end
    else if (init_window)
    begin
      if (init_cnt >= INIT_CYC - 32'h1 && i_init_done)
        init_window <= 1'b0;
      if (init_cnt < INIT_CYC - 32'h1)
        init_cnt <= init_cnt + 32'h1;
    end
  end

  // Fault latch: set wins over host clear; clear needs the condition gone
  always @*
  begin
    next_fault = fault_latch | fault_now;
    if (i_host_fault_clear)
      next_fault = fault_now;
  end

  always @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      fault_latch    <= 4'h1;
      o_fault_report <= 4'h1;
    end
    else
    begin
      fault_latch    <= next_fault;
      o_fault_report <= next_fault;
    end
  end

  // Lost connection flag per protocol: cleared once a connection is re-made
  always @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
      lost_flag <= 2'b00;
    else
    begin
      if (i_conn_lost)
        lost_flag[i_modbus_mode] <= 1'b1;
      else if (i_conn_open && !i_modbus_mode)
        lost_flag[0] <= 1'b0;
      if (!i_conn_lost && i_modbus_mode && conn_cap != 2'd0 && tcp_state == ST_PAUSE)
        lost_flag[1] <= 1'b0;
    end
  end

  // Connection count flasher: N green flashes, then a dark pause
  always @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      tcp_state  <= ST_PAUSE;
      pause_cnt  <= 32'h0000_0000;
      flash_left <= 3'h0;
    end
    else
    begin
      case (tcp_state)
        ST_PAUSE:
        begin
          // Pause ends on a blink edge so every flash is full length
          if (pause_cnt >= PAUSE_CYC - 32'h1)
          begin
            if (blink_edge)
            begin
              pause_cnt  <= 32'h0000_0000;
              flash_left <= {1'b0, conn_cap};
              if (conn_cap != 2'd0)
                tcp_state <= ST_FLASH;
            end
          end
          else
            pause_cnt <= pause_cnt + 32'h1;
        end
        ST_FLASH:
        begin
          if (blink_edge)
          begin
            if (flash_left <= 3'h1)
            begin
              flash_left <= 3'h0;
              tcp_state  <= ST_PAUSE;
            end
            else
              flash_left <= flash_left - 3'h1;
          end
        end
        default:
          tcp_state <= ST_PAUSE;
      endcase
    end
  end

  // Network LED colour selection
  always @*
  begin
    next_net = `LED_OFF;
    if (i_modbus_mode)
    begin
      if (init_window)
        next_net = blink ? `LED_RED : `LED_GREEN;
      else if (lost_flag[1])
        next_net = blink ? `LED_RED : `LED_OFF;
      else if (tcp_state == ST_FLASH)
        next_net = blink ? `LED_GREEN : `LED_OFF;
    end
    else
    begin
      if (init_window)
        next_net = blink ? `LED_RED : `LED_OFF;
      else if (i_ip_conflict)
        next_net = `LED_RED;
      else if (lost_flag[0])
        next_net = blink ? `LED_RED : `LED_OFF;
      else if (i_conn_open && i_config_valid)
        next_net = `LED_GREEN;
      else if (i_ip_held)
        next_net = blink ? `LED_GREEN : `LED_OFF;
    end
  end

  // Front LED: latched hardware faults show red, init shows dark
  always @*
  begin
    if (|fault_latch[`FLT_NOMOTOR:`FLT_SHORT])
      next_front = `LED_RED;
    else if (fault_latch[`FLT_INIT])
      next_front = `LED_OFF;
    else
      next_front = `LED_GREEN;
  end

  // Every indicator comes straight from a flop so the pins never glitch
  always @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_net_led_green   <= 1'b0;
      o_net_led_red     <= 1'b0;
      o_unit_led_green  <= 1'b0;
      o_unit_led_red    <= 1'b0;
      o_link_led        <= 1'b0;
      o_front_led_green <= 1'b0;
      o_front_led_red   <= 1'b0;
      o_discrete_out    <= 1'b0;
    end
    else
    begin
      o_net_led_green   <= next_net[0];
      o_net_led_red     <= next_net[1];
      o_unit_led_red    <= init_window & blink;
      o_unit_led_green  <= ~init_window & i_board_comm_ok;
      // Activity blanks the LED on alternate blink phases
      o_link_led        <= pins[3] & ~(pins[4] & blink);
      o_front_led_green <= next_front[0];
      o_front_led_red   <= next_front[1];
      if (i_out_is_fault)
        o_discrete_out <= ~(|next_fault);
      else
        o_discrete_out <= i_gp_out_value;
    end
  end
endmodule // status_led_fault_output

// ==== logic/led_fault_regs.vh ====
// Purpose: Constants for the status LED and fault output block
// Assumes: 125 MHz system clock
// Notes:   Times are in milliseconds; cycle counts derive from them
`ifndef LED_FAULT_REGS_VH
`define LED_FAULT_REGS_VH
`define CLK_HZ          125000000
`define CYC_PER_MS      (`CLK_HZ / 1000)
`define FLASH_HALF_MS   250
`define FLASH_HALF_CYC  (`FLASH_HALF_MS * `CYC_PER_MS)
`define PAUSE_MS        2000
`define PAUSE_CYC       (`PAUSE_MS * `CYC_PER_MS)
`define INIT_FLASH_MS   1000
`define INIT_FLASH_CYC  (`INIT_FLASH_MS * `CYC_PER_MS)
`define MAX_CONN        2'd3
// Fault word bit positions
`define FLT_INIT        0
`define FLT_SHORT       1
`define FLT_TEMP        2
`define FLT_NOMOTOR     3
`define FLT_W           4
// LED colour codes {red, green}
`define LED_OFF         2'b00
`define LED_GREEN       2'b01
`define LED_RED         2'b10
`endif

// ==== logic/pin_sync.v ====
// Purpose: Three-flop synchroniser with agreement check for a group of pins
// Assumes: Inputs asynchronous to i_clock
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
  parameter W = 4
) (
  // Clock and reset
  input  wire         i_clock,
  input  wire         i_resetn,
  // Pins
  input  wire [W-1:0] i_pin,
  output reg  [W-1:0] o_level
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  integer k;
  always @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      s1      <= {W{1'b0}};
      s2      <= {W{1'b0}};
      s3      <= {W{1'b0}};
      o_level <= {W{1'b0}};
    end
    else
    begin
      s1 <= i_pin;
      s2 <= s1;
      s3 <= s2;
      for (k = 0; k < W; k = k + 1)
        if (s2[k] == s3[k])
          o_level[k] <= s3[k];
    end
  end
endmodule // pin_sync

// ==== sim/fault_host_model.sv ====
// Purpose: Network host that clears faults and captures the fault report
// Assumes: Clear request lasts one clock, updated by non-blocking assignment on the rising edge
// Notes:   A clear only takes effect once the condition is gone
`timescale 1ns/1ps
module fault_host_model (
  // Clock and command
  input  wire       i_clock,
  input  wire       i_go,
  // Network data
  input  wire [3:0] i_report,
  output reg        o_clear,
  output reg  [3:0] o_seen
);
  initial o_clear = 1'b0;
  initial o_seen = 4'h0;
  // Rising edge with non-blocking update: the block sees the clear one edge later, no race
  always @(posedge i_clock)
  begin
    o_clear <= i_go;
    if (i_go)
      o_seen <= i_report;
  end
endmodule // fault_host_model

// ==== sim/led_fault_checker.sv ====
// Purpose: Concurrent checks on the fault output, fault latch and LEDs
// Assumes: Pins pass a short synchroniser of at most four cycles
// Notes:   Long blink counts are not checked here
`timescale 1ns/1ps
module led_fault_checker (
  // Clock and reset
  input wire       i_clock,
  input wire       i_resetn,
  // Watched ports
  input wire       i_init_done,
  input wire       i_motor_current_en,
  input wire       i_overtemp_pin,
  input wire       i_link_up_pin,
  input wire       i_link_activity,
  input wire       i_out_is_fault,
  input wire       i_gp_out_value,
  input wire       i_host_fault_clear,
  input wire [3:0] o_fault_report,
  input wire       o_link_led,
  input wire       o_front_led_green,
  input wire       o_front_led_red,
  input wire       o_discrete_out
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  a_gp_passes: assert property (!$past(i_out_is_fault) |-> o_discrete_out == $past(i_gp_out_value))
    else $error("general output wrong");
  a_fault_out_off: assert property ($past(i_out_is_fault) && o_fault_report != 4'h0 |-> !o_discrete_out)
    else $error("fault output on during fault");
  a_fault_out_on: assert property ($past(i_out_is_fault) && o_fault_report == 4'h0 |-> o_discrete_out)
    else $error("fault output off when clean");
  a_init_flag: assert property (!i_init_done |=> o_fault_report[0])
    else $error("init fault missing");
  a_temp_flag: assert property (i_overtemp_pin [*6] |=> o_fault_report[2])
    else $error("overtemp fault missing");
  a_short_cur_only: assert property ($rose(o_fault_report[1]) |-> $past(i_motor_current_en))
    else $error("short flagged without current");
  a_lock_cur_only: assert property ($rose(o_fault_report[3]) |-> $past(i_motor_current_en))
    else $error("interlock flagged without current");
  a_latch_hold: assert property (|($past(o_fault_report) & ~o_fault_report) |-> $past(i_host_fault_clear))
    else $error("fault dropped without clear");
  a_front_red: assert property (o_fault_report[3:1] != 3'h0 |-> ##[0:1] o_front_led_red)
    else $error("front led not red");
  a_front_green: assert property ((o_fault_report == 4'h0) [*2] |-> o_front_led_green && !o_front_led_red)
    else $error("front led not green");
  a_link_lit: assert property ((i_link_up_pin && !i_link_activity) [*6] |=> o_link_led)
    else $error("link led dark with link");
  a_link_dark: assert property ((!i_link_up_pin) [*6] |=> !o_link_led)
    else $error("link led lit without link");
endmodule // led_fault_checker
bind status_led_fault_output led_fault_checker i_chk (.*);

// ==== sim/tb_top.sv ====
// Purpose: Directed test of fault latch, fault output, front and link LEDs
// Assumes: Blink and init-flash counts are too long to reach here
// Notes:   Inputs change on the falling edge
`timescale 1ns/1ps
module tb_top;
  reg         i_clock = 1'b0;
  reg         i_resetn = 1'b0;
  reg         init_done = 1'b0, cur_en = 1'b0, link_up = 1'b0, act = 1'b0;
  reg         out_fault = 1'b1, gp = 1'b0, host_go = 1'b0;
  reg  [2:0]  pins = 3'h0;
  reg  [9:0]  st = 10'h0;
  wire        clear, link_led, fr_g, fr_r, dout;
  wire        net_g, net_r, unit_g;
  wire [3:0]  rep, seen;
  integer     err_total = 0, tests_run = 0, k;
  always #4 i_clock = ~i_clock;
  status_led_fault_output i_dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_init_done(init_done),
    .i_motor_current_en(cur_en), .i_modbus_mode(st[0]), .i_ip_held(st[1]), .i_ip_conflict(st[2]),
    .i_config_valid(st[3]), .i_conn_open(st[4]), .i_conn_lost(st[5]), .i_tcp_conn_count(st[7:6]),
    .i_board_comm_ok(st[8]), .i_short_pin(pins[0]), .i_overtemp_pin(pins[1]), .i_interlock_open_pin(pins[2]),
    .i_link_up_pin(link_up), .i_link_activity(act), .i_out_is_fault(out_fault), .i_gp_out_value(gp),
    .i_host_fault_clear(clear), .o_fault_report(rep), .o_net_led_green(net_g), .o_net_led_red(net_r),
    .o_unit_led_green(unit_g), .o_unit_led_red(), .o_link_led(link_led), .o_front_led_green(fr_g),
    .o_front_led_red(fr_r), .o_discrete_out(dout));
  fault_host_model i_host (.i_clock(i_clock), .i_go(host_go), .i_report(rep), .o_clear(clear), .o_seen(seen));
  task chk(input [3:0] got, input [3:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        err_total = err_total + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wt(input integer n);
    repeat (n) @(negedge i_clock);
  endtask
  task host_clear;
    begin
      wt(1);
      host_go = 1'b1;
      wt(1);
      host_go = 1'b0;
      wt(4);
    end
  endtask
  task final_report;
    begin
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // Cuts a hang short
  initial
  begin
    #400000;
    err_total = err_total + 1;
    final_report;
  end
  initial
  begin
    wt(5);
    chk(rep, 4'h1);
    chk({3'h0, dout}, 4'h0);
    wt(5);
    i_resetn = 1'b1;
    init_done = 1'b1;
    cur_en = 1'b1;
    // Modbus mode with the daughter board talking, still inside the power-up window
    st = 10'h101;
    wt(8);
    chk(rep, 4'h1);
    chk({2'h0, net_r & net_g, net_r | net_g}, 4'h1);
    chk({3'h0, unit_g}, 4'h0);
    host_clear;
    chk(rep, 4'h0);
    chk(seen, 4'h1);
    chk({3'h0, dout}, 4'h1);
    out_fault = 1'b0;
    gp = 1'b1;
    wt(3);
    chk({3'h0, dout}, 4'h1);
    gp = 1'b0;
    wt(3);
    chk({3'h0, dout}, 4'h0);
    out_fault = 1'b1;
    wt(3);
    chk({3'h0, dout}, 4'h1);
    for (k = 0; k < 3; k = k + 1)
    begin
      pins = 3'h1 << k;
      wt(8);
      chk(rep, {pins, 1'b0});
      chk({3'h0, dout}, 4'h0);
      chk({2'h0, fr_r, fr_g}, 4'h2);
      host_clear;
      chk(rep, {pins, 1'b0});
      pins = 3'h0;
      wt(8);
      chk(rep, {3'h1 << k, 1'b0});
      host_clear;
      chk(rep, 4'h0);
      chk({2'h0, fr_r, fr_g}, 4'h1);
    end
    cur_en = 1'b0;
    pins = 3'h5;
    wt(8);
    chk(rep, 4'h0);
    pins = 3'h0;
    link_up = 1'b1;
    wt(8);
    chk({3'h0, link_led}, 4'h1);
    link_up = 1'b0;
    wt(8);
    chk({3'h0, link_led}, 4'h0);
    init_done = 1'b0;
    wt(3);
    chk(rep, 4'h1);
    chk({3'h0, dout}, 4'h0);
    final_report;
  end
endmodule // tb_top
